// ==== logic/disc_sector_transfer_sequencer.sv ====
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// R1: first parity byte is even parity of odd bytes, second of even bytes.
// R2: normal modes raise byte end at byte 255 into the last-byte chain.
// R3: after byte end's next byte, stop data and send two parity bytes.
// R4: bit-7 strobe after parity sets write end; zeros are written afterwards.
// R5: write end ends the operation; write gate stays until sector mark or clear.
// R6: read format starts on sector compare by setting the data read gate.
// R7: format modes raise byte end at byte 269 instead.
// R8: write start is normal start or write format with sector compare.
// R9: format modes raise no address compare or defective track errors.
// R10: channel alone ends the transfer; device probes with one extra request.
// R11: read check sets check flags, one last request, continue if answered.
// R12: continue forces sector compare, disables address compare, restarts operation.
// R13: write last-byte flag blocks requests after one final probing request.
// R14: unanswered final write request lets write end complete the operation.
// R15: answered final write request suppresses completion and sets continue.
// R16: index store sets on index, clears after first following sector mark.
// R17: index store, sector mark and continue switch head 0 to head 1.
// R18: same condition on head 1 sets cylinder overflow, examine, write inhibit.
// R19: one 12-bit counter, low three bits count bits, decodes 3 and 7.
// R20: byte end decode picks 269 in format commands, 255 otherwise.
// R21: track address is data input register plus data output register bit 7.
// R22: two-stage overrun counter counts index store while busy.
// R23: read parity check compares each bit; sticky error never set writing.
// R24: channel answers each request with a byte; device then drops request.
// R25: single clock; general clear returns everything to idle.
module disc_sector_transfer_sequencer
    import sector_seq_pkg::*;
#(
    parameter int BYTE_DATA_W = sector_seq_pkg::DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic general_clear_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // selector channel byte handshake
    input wire logic [sector_seq_pkg::DATA_W-1:0] data_i,
    input wire logic data_available_i,
    output logic data_request_o,
    output logic [sector_seq_pkg::DATA_W-1:0] data_o,
    // drive side
    input wire logic sector_mark_i,
    input wire logic index_mark_i,
    input wire logic sector_compare_i,
    input wire logic data_start_i,
    input wire logic addr_compare_fail_i,
    input wire logic defective_track_i,
    input wire logic read_data_i,
    input wire logic read_bit_count_pulse_i,
    input wire logic write_bit_count_pulse_i,
    output logic write_data_o,
    output logic write_gate_o,
    output logic data_read_gate_o,
    output logic addr_compare_enable_o,
    output logic head_select_o,
    output logic [sector_seq_pkg::TA_W-1:0] track_address_o,
    output logic operation_complete_o,
    output logic controller_busy_o,
    output logic bit_count3_o,
    output logic bit_count7_o
);
    import sector_seq_pkg::*;

    // the serial paths are written for byte-wide data only
    if (BYTE_DATA_W != DATA_W) begin : g_width_check
        $error("BYTE_DATA_W must equal 8");
    end

    typedef struct packed {
        op_state_type state;
        logic busy;
        logic is_write;
        logic is_format;
        logic [CNT_W-1:0] cnt;
        logic [CHAIN_W-1:0] chain;   // [0] last_byte_chain_stage, [1] write_last_byte
        logic [PAR_W-1:0] par;
        logic [DATA_W-1:0] dir;
        logic [DATA_W-1:0] data_output_register;
        logic [DATA_W-1:0] dar;
        logic dreq;                  // pending_data_request
        logic last_data_byte;
        logic data_output_enable;
        logic write_end;
        logic write_gate;
        logic data_read_gate;
        logic check_cycle_flag;
        logic check_cycle_second_flag;
        logic continue_flag;
        logic index_store;
        logic sm_prev;
        logic head_select;
        logic cylinder_overflow;
        logic ov_first;
        logic ov_second;
        logic parity_error_flag;
        logic addr_error;
        logic defect_error;
        logic op_cmp;
        logic wdata;
        logic ack;
        logic [31:0] rdata;
    } state_type;

    localparam state_type RESET_STATE = '{state: ST_IDLE, default: '0};

    state_type s_r;
    state_type s_nxt;
    logic sm_rise;
    logic sm_fall;
    logic sector_compare;
    logic restart;
    logic wr_start;
    logic rd_start;
    logic bit_pulse;
    logic strobe;
    logic byte_end;
    logic op_end;
    logic out_bit;
    logic examine;
    logic wb_req;

    // bit-7 decode is needed by the strobe and by the decode output
    function automatic logic at_bit7(input logic [CNT_W-1:0] c);
        return c[BIT_W-1:0] == BIT_COUNT7;
    endfunction : at_bit7

    function automatic logic [BYTE_W-1:0] byte_of(input logic [CNT_W-1:0] c);
        return c[CNT_W-1:BIT_W];
    endfunction : byte_of

    assign examine = s_r.cylinder_overflow | s_r.ov_second | s_r.addr_error | s_r.defect_error;
    assign wb_req = cyc_i & stb_i & ~s_r.ack;

    // next-state logic of the whole sequencer
    always_comb begin
        s_nxt = s_r;
        sm_rise = sector_mark_i & ~s_r.sm_prev;
        sm_fall = ~sector_mark_i & s_r.sm_prev;
        sector_compare = sector_compare_i | (s_r.continue_flag & sm_rise); // [R12]
        restart = s_r.busy & s_r.continue_flag & sector_compare; // [R12]
        wr_start = s_r.busy & s_r.is_write & (s_r.state == ST_IDLE)
                 & ((data_start_i & ~s_r.is_format) | (s_r.is_format & sector_compare) | restart); // [R8]
        rd_start = s_r.busy & ~s_r.is_write & (s_r.state == ST_IDLE)
                 & ((data_start_i & ~s_r.is_format) | (s_r.is_format & sector_compare) | restart); // [R6]
        case (s_r.state)
            ST_READ: bit_pulse = read_bit_count_pulse_i;
            ST_WRITE: bit_pulse = write_bit_count_pulse_i;
            default: bit_pulse = 1'b0;
        endcase
        strobe = bit_pulse & at_bit7(s_r.cnt);
        byte_end = strobe & (byte_of(s_r.cnt) ==
                   (s_r.is_format ? BYTE_END_FORMAT : BYTE_END_NORMAL)); // [R2] [R7] [R20]
        op_end = 1'b0;
        out_bit = s_r.data_output_enable ? s_r.data_output_register[s_r.cnt[BIT_W-1:0]]
                : (s_r.chain[1] & ~s_r.write_end) ? s_r.par[PAR_W-1] : 1'b0; // [R3] [R4]
        s_nxt.sm_prev = sector_mark_i;
        s_nxt.op_cmp = 1'b0;

        // one counter for bits and bytes
        if (sector_mark_i | wr_start | rd_start) begin
            s_nxt.cnt = '0; // [R19]
        end else if (bit_pulse) begin
            s_nxt.cnt = s_r.cnt + 1'b1; // [R19]
        end

        // channel answers a raised request with a byte
        if (s_r.dreq & data_available_i) begin
            s_nxt.dreq = 1'b0; // [R24] [R10]
            if (s_r.is_write) begin
                s_nxt.dir = data_i;
            end
        end

        case (s_r.state)
            ST_IDLE: begin
                // zero fill: cells after write end carry no data, not the last parity bit
                if (write_bit_count_pulse_i) begin
                    s_nxt.wdata = 1'b0; // [R4]
                end
                if (wr_start) begin
                    s_nxt.state = ST_WRITE;
                    s_nxt.write_gate = 1'b1;
                    s_nxt.dreq = ~restart; // a continued write already holds the probe byte [R15]
                    s_nxt.par = '0;
                    s_nxt.chain = '0;
                    s_nxt.continue_flag = 1'b0;
                end else if (rd_start) begin
                    s_nxt.state = ST_READ;
                    s_nxt.data_read_gate = 1'b1; // [R6]
                    s_nxt.par = '0;
                    s_nxt.chain = '0;
                    s_nxt.continue_flag = 1'b0;
                end
            end
            ST_WRITE: begin
                if (bit_pulse) begin
                    s_nxt.wdata = out_bit; // zeros once parity is off [R4]
                    s_nxt.par = {s_r.par[PAR_W-2:0],
                                 s_r.par[PAR_W-1] ^ (s_r.data_output_enable & out_bit)}; // [R1]
                end
                if (strobe) begin
                    s_nxt.chain = {s_r.chain[CHAIN_W-2:0], s_r.chain[0] | byte_end}; // [R2]
                    s_nxt.data_output_enable = ~s_r.chain[0]; // [R3]
                    if (!s_r.chain[0]) begin
                        s_nxt.data_output_register = s_r.dir;
                        s_nxt.dreq = s_r.dreq | ~s_r.last_data_byte; // [R13]
                        s_nxt.last_data_byte = s_r.last_data_byte | byte_end; // [R13]
                    end
                    if (s_r.chain[2]) begin
                        s_nxt.write_end = 1'b1; // [R4]
                    end
                end
                // answered probe: continue into the next sector
                if (s_r.chain[1] & ~s_r.write_end & s_r.last_data_byte & ~s_r.dreq) begin
                    s_nxt.continue_flag = 1'b1; // [R15]
                end
                if (s_r.write_end) begin
                    op_end = 1'b1; // [R5]
                    s_nxt.state = ST_IDLE;
                    s_nxt.chain = '0;
                    s_nxt.last_data_byte = 1'b0;
                    s_nxt.data_output_enable = 1'b0;
                    s_nxt.write_end = 1'b0;
                end
            end
            ST_READ: begin
                if (bit_pulse) begin
                    s_nxt.dar = {read_data_i, s_r.dar[DATA_W-1:1]};
                    if (s_r.chain[1]) begin
                        s_nxt.par = {s_r.par[PAR_W-2:0], s_r.par[PAR_W-1]};
                        if (read_data_i != s_r.par[PAR_W-1]) begin
                            s_nxt.parity_error_flag = 1'b1; // [R23]
                        end
                    end else if (byte_of(s_r.cnt) != SYNC_BYTE) begin
                        s_nxt.par = {s_r.par[PAR_W-2:0], s_r.par[PAR_W-1] ^ read_data_i}; // [R1]
                    end
                end
                if (strobe) begin
                    s_nxt.chain = {s_r.chain[CHAIN_W-2:0], s_r.chain[0] | byte_end}; // [R2]
                    if (!s_r.chain[1] && byte_of(s_r.cnt) != SYNC_BYTE) begin
                        s_nxt.data_output_register = {read_data_i, s_r.dar[DATA_W-1:1]};
                        s_nxt.dreq = s_r.dreq | ~s_r.check_cycle_flag; // [R11]
                        s_nxt.check_cycle_flag = s_r.check_cycle_flag | s_r.chain[0]; // [R11]
                    end
                    if (s_r.check_cycle_flag & ~s_r.check_cycle_second_flag) begin
                        s_nxt.check_cycle_second_flag = 1'b1;
                        s_nxt.continue_flag = ~s_r.dreq; // [R11] [R10]
                    end
                    if (s_r.chain[2]) begin
                        op_end = 1'b1;
                        s_nxt.state = ST_IDLE;
                        s_nxt.chain = '0;
                        s_nxt.data_read_gate = 1'b0;
                        s_nxt.check_cycle_flag = 1'b0;
                        s_nxt.check_cycle_second_flag = 1'b0;
                    end
                end
            end
            default: s_nxt.state = ST_IDLE;
        endcase

        // completion only when the channel left the last request hanging
        if (op_end & s_r.dreq) begin
            s_nxt.op_cmp = 1'b1; // [R14]
            s_nxt.busy = 1'b0;
            s_nxt.dreq = 1'b0;
            s_nxt.continue_flag = 1'b0;
        end

        // zero fill runs on until the sector boundary
        if (sector_mark_i & ~wr_start) begin
            s_nxt.write_gate = 1'b0; // [R5]
        end

        // index store and automatic head switch
        if (index_mark_i) begin
            s_nxt.index_store = 1'b1; // [R16]
        end else if (sm_fall) begin
            s_nxt.index_store = 1'b0; // [R16]
        end
        if (s_r.index_store & sm_rise & s_r.continue_flag) begin
            if (s_r.head_select) begin
                s_nxt.cylinder_overflow = 1'b1; // [R18]
            end else begin
                s_nxt.head_select = 1'b1; // [R17]
            end
        end

        // overrun: second stage only falls when the controller idles
        if (!s_r.busy) begin
            s_nxt.ov_first = 1'b0; // [R22]
            s_nxt.ov_second = 1'b0;
        end else if (sector_compare && !s_r.ov_second) begin
            s_nxt.ov_first = 1'b0; // [R22]
        end else if (index_mark_i & ~s_r.index_store) begin
            s_nxt.ov_first = ~s_r.ov_first;
            s_nxt.ov_second = s_r.ov_second | s_r.ov_first; // [R22]
        end

        // address errors are meaningless without an address read
        if (s_r.busy & ~s_r.is_format & ~s_r.continue_flag) begin
            s_nxt.addr_error = s_r.addr_error | addr_compare_fail_i; // [R9]
            s_nxt.defect_error = s_r.defect_error | defective_track_i; // [R9]
        end

        // wishbone: one wait state, registered ack and read data
        s_nxt.ack = wb_req;
        s_nxt.rdata = '0;
        if (wb_req && !we_i && adr_i == STATUS_OFFSET) begin
            s_nxt.rdata[ST_BUSY_BIT] = s_r.busy;
            s_nxt.rdata[ST_CONTINUE_FLAG_BIT] = s_r.continue_flag;
            s_nxt.rdata[ST_HEAD_BIT] = s_r.head_select;
            s_nxt.rdata[ST_CYLINDER_OVERFLOW_BIT] = s_r.cylinder_overflow;
            s_nxt.rdata[ST_OVERRUN_BIT] = s_r.ov_second;
            s_nxt.rdata[ST_PARERR_BIT] = s_r.parity_error_flag;
            s_nxt.rdata[ST_ADDRERR_BIT] = s_r.addr_error;
            s_nxt.rdata[ST_DEFTRK_BIT] = s_r.defect_error;
            s_nxt.rdata[ST_EXAMINE_BIT] = examine;
            s_nxt.rdata[ST_WGATE_BIT] = s_r.write_gate;
        end else if (wb_req && !we_i && adr_i == CTRL_OFFSET) begin
            s_nxt.rdata[CTRL_WRITE_BIT] = s_r.is_write;
            s_nxt.rdata[CTRL_FORMAT_BIT] = s_r.is_format;
            s_nxt.rdata[CTRL_HEAD_BIT] = s_r.head_select;
        end
        // a new command is refused while busy
        if (wb_req && we_i && sel_i[0] && adr_i == CTRL_OFFSET && !s_r.busy
                && dat_i[CTRL_GO_BIT]) begin
            s_nxt.busy = 1'b1;
            s_nxt.is_write = dat_i[CTRL_WRITE_BIT];
            s_nxt.is_format = dat_i[CTRL_FORMAT_BIT];
            s_nxt.head_select = dat_i[CTRL_HEAD_BIT];
            s_nxt.parity_error_flag = 1'b0;
            s_nxt.addr_error = 1'b0;
            s_nxt.defect_error = 1'b0;
            s_nxt.cylinder_overflow = 1'b0;
            s_nxt.dreq = 1'b0;
        end

        if (general_clear_i) begin
            s_nxt = RESET_STATE; // [R25]
        end
    end

    // single clock domain for every flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= RESET_STATE; // [R25]
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dat_o = s_r.rdata;
    assign ack_o = s_r.ack;
    assign data_request_o = s_r.dreq;
    assign data_o = s_r.data_output_register;
    assign write_data_o = s_r.wdata;
    assign write_gate_o = s_r.write_gate & ~examine; // examine protects the disc [R18]
    assign data_read_gate_o = s_r.data_read_gate;
    assign addr_compare_enable_o = s_r.busy & ~s_r.is_format & ~s_r.continue_flag; // [R12] [R9]
    assign head_select_o = s_r.head_select;
    assign track_address_o = {s_r.data_output_register[DATA_W-1], s_r.dir}; // [R21]
    assign operation_complete_o = s_r.op_cmp;
    assign controller_busy_o = s_r.busy;
    assign bit_count3_o = s_r.cnt[BIT_W-1:0] == BIT_COUNT3; // [R19]
    assign bit_count7_o = at_bit7(s_r.cnt); // [R19]

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || general_clear_i);

    property p_byte_end_normal;
        strobe && !s_r.is_format && byte_of(s_r.cnt) == BYTE_END_NORMAL |=> s_r.chain[0];
    endproperty
    a_byte_end_normal: assert property (p_byte_end_normal) else $error("no byte end at 255"); // [R2]
    property p_format_no_early_end;
        strobe && s_r.is_format && !s_r.chain[0] && byte_of(s_r.cnt) == BYTE_END_NORMAL
            |=> !s_r.chain[0];
    endproperty
    a_format_no_early_end: assert property (p_format_no_early_end) else $error("format end early"); // [R7]
    property p_gate_after_end;
        s_r.state == ST_WRITE && s_r.write_end && !sector_mark_i
            |=> s_r.write_gate && s_r.state == ST_IDLE;
    endproperty
    a_gate_after_end: assert property (p_gate_after_end) else $error("write gate lost"); // [R5]
    property p_no_perr_write;
        s_r.state == ST_WRITE |=> $stable(s_r.parity_error_flag);
    endproperty
    a_no_perr_write: assert property (p_no_perr_write) else $error("parity error in write"); // [R23]
    property p_complete;
        s_r.state == ST_WRITE && s_r.write_end && s_r.dreq
            |=> operation_complete_o && !controller_busy_o ##1 !operation_complete_o;
    endproperty
    a_complete: assert property (p_complete) else $error("write did not complete"); // [R14]
    property p_no_complete;
        s_r.state == ST_WRITE && s_r.write_end && !s_r.dreq |=> !operation_complete_o;
    endproperty
    a_no_complete: assert property (p_no_complete) else $error("completion not held"); // [R15]
    property p_head_switch;
        s_r.index_store && sm_rise && s_r.continue_flag && !s_r.head_select |=> head_select_o;
    endproperty
    a_head_switch: assert property (p_head_switch) else $error("head not switched"); // [R17]
    property p_cyl_overflow;
        s_r.index_store && sm_rise && s_r.continue_flag && s_r.head_select
            |=> s_r.cylinder_overflow && !write_gate_o;
    endproperty
    a_cyl_overflow: assert property (p_cyl_overflow) else $error("no cylinder overflow"); // [R18]
    property p_overrun_idle;
        !s_r.busy |=> !s_r.ov_second;
    endproperty
    a_overrun_idle: assert property (p_overrun_idle) else $error("overrun while idle"); // [R22]
    property p_read_format_start;
        s_r.busy && !s_r.is_write && s_r.is_format && s_r.state == ST_IDLE && sector_compare_i
            |=> data_read_gate_o;
    endproperty
    a_read_format_start: assert property (p_read_format_start) else $error("no read gate"); // [R6]
endmodule : disc_sector_transfer_sequencer

// ==== logic/sector_seq_pkg.sv ====
package sector_seq_pkg;
    // combined bit/byte counter layout
    localparam int CNT_W = 12;
    localparam int BIT_W = 3;
    localparam int BYTE_W = CNT_W - BIT_W;
    localparam int DATA_W = 8;
    localparam int PAR_W = 2 * DATA_W;
    localparam int TA_W = DATA_W + 1;
    localparam int CHAIN_W = 3;
    localparam logic [BIT_W-1:0] BIT_COUNT3 = 3'h3;
    localparam logic [BIT_W-1:0] BIT_COUNT7 = 3'h7;
    localparam logic [BYTE_W-1:0] BYTE_END_NORMAL = 9'h0ff;
    localparam logic [BYTE_W-1:0] BYTE_END_FORMAT = 9'h10d;
    localparam logic [BYTE_W-1:0] SYNC_BYTE = 9'h000;
    // wishbone register map, byte addresses
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    // control register fields
    localparam int CTRL_WRITE_BIT = 0;
    localparam int CTRL_FORMAT_BIT = 1;
    localparam int CTRL_GO_BIT = 2;
    localparam int CTRL_HEAD_BIT = 3;
    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_CONTINUE_FLAG_BIT = 1;
    localparam int ST_HEAD_BIT = 2;
    localparam int ST_CYLINDER_OVERFLOW_BIT = 3;
    localparam int ST_OVERRUN_BIT = 4;
    localparam int ST_PARERR_BIT = 5;
    localparam int ST_ADDRERR_BIT = 6;
    localparam int ST_DEFTRK_BIT = 7;
    localparam int ST_EXAMINE_BIT = 8;
    localparam int ST_WGATE_BIT = 9;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } op_state_type;
endpackage : sector_seq_pkg

// ==== tb/channel_model.sv ====
`timescale 1ns/1ps
// selector channel: answers each request once while its byte budget lasts
module channel_model (
    input wire logic clk_i,
    input wire logic data_request_i,
    input wire logic [7:0] rx_i,
    input wire logic [31:0] limit_i,
    output logic data_available_o,
    output logic [7:0] data_o,
    output logic [7:0] rx_o,
    output int count_o
);
    initial begin
        data_available_o = 1'b0;
        data_o = 8'h00;
        rx_o = 8'h00;
        count_o = 0;
    end
    // a released bus shows the inverted byte so stale data never looks valid
    always @(posedge clk_i) begin
        if (data_available_o && data_request_i) begin
            data_available_o <= 1'b0;
            data_o <= ~data_o;
            rx_o <= rx_i;
            count_o <= count_o + 1;
        end else if (data_request_i && count_o < limit_i) begin
            data_available_o <= 1'b1;
            data_o <= 8'h5a ^ count_o[7:0];
        end
    end
endmodule : channel_model

// ==== tb/test_disc_sector_transfer_sequencer.sv ====
`timescale 1ns/1ps
module test_disc_sector_transfer_sequencer;
    import sector_seq_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cs = 1'b0, we = 1'b0, ack, da, req, acf = 1'b0;
    logic rdd = 1'b0, rbc = 1'b0, wbc = 1'b0, wdo, wg, drg, ace, hs, opc, busy, b3, b7;
    logic [4:0] ev = 5'h00;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic [7:0] chd, outd, rx;
    logic [8:0] ta;
    logic [7:0] rbuf [0:299], wbuf [0:299];
    int lim = 0, cnt, failures = 0, check_count = 0, done_cnt = 0, d0;
    disc_sector_transfer_sequencer disc_sector_transfer_sequencer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .general_clear_i(ev[4]), .cyc_i(cs), .stb_i(cs),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
        .data_i(chd), .data_available_i(da), .data_request_o(req), .data_o(outd),
        .sector_mark_i(ev[0]), .index_mark_i(ev[1]), .sector_compare_i(ev[2]),
        .data_start_i(ev[3]), .addr_compare_fail_i(acf), .defective_track_i(1'b0),
        .read_data_i(rdd), .read_bit_count_pulse_i(rbc), .write_bit_count_pulse_i(wbc),
        .write_data_o(wdo), .write_gate_o(wg), .data_read_gate_o(drg),
        .addr_compare_enable_o(ace), .head_select_o(hs), .track_address_o(ta),
        .operation_complete_o(opc), .controller_busy_o(busy), .bit_count3_o(b3),
        .bit_count7_o(b7));
    channel_model channel_model_inst (.clk_i(clk_i), .data_request_i(req), .rx_i(outd),
        .limit_i(lim), .data_available_o(da), .data_o(chd), .rx_o(rx), .count_o(cnt));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // completion is a one-cycle pulse, so count it where it stands
    always @(posedge clk_i) begin
        if (opc === 1'b1) done_cnt <= done_cnt + 1;
    end
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    // compare away from the edge so updates have landed
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        @(negedge clk_i);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cs <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cs <= 1'b0;
        // a missing acknowledge counts as a mismatch
        if (ack !== 1'b1) chk(32'h0, 32'h1);
    endtask : wb
    task automatic ping(input logic [4:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 5'h00;
        repeat (3) @(posedge clk_i);
    endtask : ping
    // two cycles per bit cell, three in byte 1 where the decode is checked; the written bit is sampled once the pulse edge has set it
    task automatic sector(input logic w, input int n);
        for (int k = 0; k < n; k++) begin
            for (int b = 0; b < 8; b++) begin
                @(posedge clk_i);
                wbc <= w;
                rbc <= !w;
                rdd <= rbuf[k][b];
                @(posedge clk_i);
                wbc <= 1'b0;
                rbc <= 1'b0;
                @(negedge clk_i);
                wbuf[k][b] = wdo;
                if (k == 1) chk({b3, b7}, {30'h0, b == 2, b == 6});
            end
        end
    endtask : sector
    // odd data bytes fold into the first parity byte, even into the second
    function automatic logic [15:0] lpar(input logic [7:0] v [0:299], input int last);
        logic [15:0] p;
        p = 16'h0000;
        for (int k = 1; k <= last; k++) p = p ^ ((k % 2) ? {v[k], 8'h00} : {8'h00, v[k]});
        return p;
    endfunction : lpar
    task automatic wrt(input logic fmt, input int budget);
        int last;
        int c0;
        last = fmt ? 270 : 256;
        c0 = cnt;
        @(posedge clk_i);
        acf <= fmt;
        lim <= cnt + budget;
        wb(1'b1, CTRL_OFFSET, 32'h5 | {30'h0, fmt, 1'b0});
        ping(fmt ? 5'h04 : 5'h08);
        chk({busy, ace}, {1'b1, !fmt});
        sector(1'b1, last + 4);
        chk({wbuf[last + 1], wbuf[last + 2]}, lpar(wbuf, last));
        chk(wbuf[1], 8'h5a ^ c0[7:0]);
        chk(wbuf[last + 3], 8'h00);
    endtask : wrt
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, STATUS_OFFSET, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        d0 = done_cnt;
        wrt(1'b0, 4);
        chk(done_cnt, d0 + 1);
        chk(ta, 9'h059);
        chk(wg, 1'b1);
        ping(5'h01);
        chk(wg, 1'b0);
        $display("test single write done");
        wrt(1'b1, 3);
        wb(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[ST_ADDRERR_BIT], 1'b0);
        ping(5'h01);
        $display("test format write done");
        d0 = done_cnt;
        wrt(1'b0, 1000);
        wb(1'b0, STATUS_OFFSET, 32'h0);
        chk({q[ST_CONTINUE_FLAG_BIT], done_cnt[0]}, {1'b1, d0[0]});
        ping(5'h02);
        ping(5'h01);
        chk(hs, 1'b1);
        sector(1'b1, 260);
        ping(5'h02);
        ping(5'h01);
        wb(1'b0, STATUS_OFFSET, 32'h0);
        chk({hs, q[ST_CYLINDER_OVERFLOW_BIT], q[ST_EXAMINE_BIT], wg}, 4'b1110);
        ping(5'h10);
        chk(hs, 1'b0);
        $display("test continue done");
        for (int e = 0; e < 2; e++) begin
            rbuf[0] = 8'h00;
            for (int k = 1; k <= 256; k++) rbuf[k] = 8'h31 * k[7:0] + 8'h07;
            {rbuf[257], rbuf[258]} = lpar(rbuf, 256) ^ {15'h0, e[0]};
            d0 = done_cnt;
            lim <= cnt + (e ? 1000 : 3);
            wb(1'b1, CTRL_OFFSET, 32'h4);
            ping(5'h08);
            sector(1'b0, 262);
            wb(1'b0, STATUS_OFFSET, 32'h0);
            chk(q[ST_PARERR_BIT], e[0]);
            chk({q[ST_CONTINUE_FLAG_BIT], rx}, {e[0], e ? rbuf[256] : rbuf[3]});
            chk(done_cnt, d0 + 1 - e);
            ping(e ? 5'h10 : 5'h01);
        end
        $display("test read parity done");
        wb(1'b1, CTRL_OFFSET, 32'h6);
        ping(5'h02);
        ping(5'h01);
        ping(5'h02);
        ping(5'h01);
        wb(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[ST_OVERRUN_BIT], 1'b1);
        ping(5'h04);
        chk(drg, 1'b1);
        ping(5'h10);
        wb(1'b0, STATUS_OFFSET, 32'h0);
        chk(q, 32'h0);
        $display("test overrun done");
        print_verdict();
    end
    initial begin
        repeat (95000) @(posedge clk_i);
        failures++;
        print_verdict();
    end
endmodule : test_disc_sector_transfer_sequencer
